// file: inc/rxwake_pkg.sv
// shared constants for the receive-pin wake-up controller
package rxwake_pkg;
    // register byte offsets (32-bit aligned words)
    localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_BAUD       = 8'h0c;
    localparam logic [7:0] OFS_TXDATA     = 8'h10;
    localparam logic [7:0] OFS_RXDATA     = 8'h14;
    localparam logic [7:0] OFS_IRQ_CTRL   = 8'h18;
    localparam logic [7:0] OFS_EVT_STAT   = 8'h1c;
    localparam logic [7:0] OFS_EVT_MASK   = 8'h20;
    localparam logic [7:0] OFS_POWER_MODE = 8'h24;
    // control one fields
    localparam int BIT_MODULE_EN   = 7;
    // control two fields
    localparam int BIT_RX_EN       = 6;
    localparam int BIT_WAKE_EN     = 3;
    localparam int BIT_RX_IRQ_EN   = 2;
    // interrupt control fields
    localparam int BIT_GLOBAL_IRQ  = 0;
    localparam int BIT_SERIAL_IRQ  = 1;
    // status fields
    localparam int BIT_RX_IDLE     = 0;
    localparam int BIT_RX_DONE     = 1;
    // event status fields
    localparam int EVT_WAKE        = 0;
    localparam int EVT_RX_DONE     = 1;
    localparam int EVT_GUARD_DONE  = 2;
    localparam int EVT_W           = 3;
    // reset values
    localparam logic [7:0] RST_CTRL    = 8'h00;
    localparam logic [7:0] RST_BAUD    = 8'h0f;
    localparam logic [7:0] RST_STATUS  = 8'h01;
    // start-up time after wake, and its count at 25 MHz
    localparam int STARTUP_NS   = 2000;
    localparam int CLK_NS       = 40;
    localparam int STARTUP_CYC  = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
    // power modes
    typedef enum logic [1:0] {
        PM_RUN, PM_IDLE_SUB, PM_IDLE_FAST, PM_SLEEP
    } power_mode_t;
endpackage

// file: core/rx_serial_engine.sv
// receive shift engine with clock-gate pause
module rx_serial_engine
    import rxwake_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic       enable,
    input  wire logic       rx_in,
    input  wire logic [7:0] divisor,
    output logic            busy,
    output logic            done,
    output logic [7:0]      data
);
    typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} rx_state_t;
    rx_state_t  state_r;
    logic [7:0] tick_r;
    logic [2:0] bit_r;
    logic [7:0] shift_r;

    // baud counter pauses while run is low, so a frame is held mid-way
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= S_IDLE;
            tick_r  <= 8'h00;
            bit_r   <= 3'h0;
            shift_r <= 8'h00;
            data    <= 8'h00;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (run) begin
                unique case (state_r)
                    S_IDLE: begin
                        if (enable && !rx_in) begin
                            state_r <= S_START;
                            tick_r  <= {1'b0, divisor[7:1]};
                        end
                    end
                    S_START: begin
                        if (tick_r == 8'h00) begin
                            tick_r  <= divisor;
                            bit_r   <= 3'h0;
                            state_r <= rx_in ? S_IDLE : S_DATA;
                        end else begin
                            tick_r <= tick_r - 8'h01;
                        end
                    end
                    S_DATA: begin
                        if (tick_r == 8'h00) begin
                            tick_r  <= divisor;
                            shift_r <= {rx_in, shift_r[7:1]};
                            bit_r   <= bit_r + 3'h1;
                            if (bit_r == 3'h7) begin
                                state_r <= S_STOP;
                            end
                        end else begin
                            tick_r <= tick_r - 8'h01;
                        end
                    end
                    S_STOP: begin
                        if (tick_r == 8'h00) begin
                            state_r <= S_IDLE;
                            data    <= shift_r;
                            done    <= 1'b1;
                        end else begin
                            tick_r <= tick_r - 8'h01;
                        end
                    end
                endcase
            end
        end
    end

    assign busy = (state_r != S_IDLE);
endmodule

// file: core/rx_wakeup_ctrl.sv
// receive-pin wake-up and power-down control for the serial port
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - with the system clock stopped the port has no clock and frozen transfers resume later.
// - entering power-down during a reception pauses it instead of dropping it.
// - idle and sleep entry leave status, both controls, data and divisor untouched.
// - wake enable is bit 3 and receive irq enable bit 2 of control two.
// - wake, module, receiver and receive irq enables set make a falling rx edge wake the cpu from sub idle or sleep.
// - rx data during start-up after a wake is discarded.
// - a wake raises an interrupt only with global and serial irq enables set; the code's EVT_GUARD_DONE event still reaches irq without them.
// - the wake interrupt is held back until start-up has elapsed.
// - in sleep an enabled falling edge restarts the system clock and wakes the cpu.
// - in fast idle an rx edge with no transfer keeps the clock running and the cpu halted.
// - in fast idle with wake and receive irq enabled, transfer end wakes the cpu.
// - in fast idle with receive irq off, reception end does not wake the cpu.
// - the rx wake is a serial irq source without its own flag, gated by wake and receive irq; the code latches it in EVT_WAKE.
module rx_wakeup_ctrl
    import rxwake_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hsel,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rx_pin,
    output logic             sys_clk_run,
    output logic             cpu_wake,
    output logic             serial_irq,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  serial_control_one_r;
    logic [7:0]  serial_control_two_r;
    logic [7:0]  baud_divisor_reg_r;
    logic [7:0]  tx_data_r;
    logic [1:0]  irq_ctrl_r;
    logic [EVT_W-1:0] evt_stat_r;
    logic [EVT_W-1:0] evt_mask_r;
    power_mode_t mode_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [2:0]  rx_sync_r;
    logic        rx_clean_r;
    logic        edge_latch_r;
    logic        edge_seen_r;
    logic        guard_r;
    logic [$clog2(STARTUP_CYC+1)-1:0] guard_cnt_r;
    logic        irq_hold_r;
    logic        rx_busy;
    logic        rx_done;
    logic [7:0]  rx_data;
    logic        wake_armed;
    logic        halted;
    logic        clk_off;
    logic [EVT_W-1:0] evt_set;

    // field helpers
    function automatic logic bit_of(input logic [7:0] v, input int idx);
        return v[idx];
    endfunction

    assign wake_armed = bit_of(serial_control_two_r, BIT_WAKE_EN)
                     && bit_of(serial_control_two_r, BIT_RX_IRQ_EN)
                     && bit_of(serial_control_one_r, BIT_MODULE_EN)
                     && bit_of(serial_control_two_r, BIT_RX_EN);
    assign halted  = (mode_r != PM_RUN);
    // fast idle keeps the system clock; sub idle and sleep stop it
    assign clk_off = (mode_r == PM_IDLE_SUB) || (mode_r == PM_SLEEP);
    assign sys_clk_run = !clk_off;
    assign cpu_wake    = !halted;

    ////////////////////////////////////////////////////////////////////////////
    // receive pin synchroniser, change counts when stages two and three agree
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_sync_r  <= 3'h7;
            rx_clean_r <= 1'b1;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], rx_pin};
            if (rx_sync_r[1] == rx_sync_r[2]) begin
                rx_clean_r <= rx_sync_r[2];
            end
        end
    end

    // clockless falling-edge catch; cleared only by reset
    always_ff @(negedge rx_pin or negedge resetn) begin
        if (!resetn) begin
            edge_latch_r <= 1'b0;
        end else begin
            edge_latch_r <= 1'b1;
        end
    end

    // edge_latch_r is asynchronous; sample it only as a wake request
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            edge_seen_r <= 1'b0;
        end else begin
            edge_seen_r <= edge_latch_r;
        end
    end

    // receiver frozen with the system clock; no new frame starts during start-up guard
    rx_serial_engine u_engine (
        .core_clk (core_clk),
        .resetn   (resetn),
        .run      (!clk_off),
        .enable   (bit_of(serial_control_one_r, BIT_MODULE_EN)
                   && bit_of(serial_control_two_r, BIT_RX_EN) && !guard_r),
        .rx_in    (rx_clean_r),
        .divisor  (baud_divisor_reg_r),
        .busy     (rx_busy),
        .done     (rx_done),
        .data     (rx_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // power mode: software enters, wake sources leave
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= PM_RUN;
        end else if (wr_pend_r && wr_addr_r == OFS_POWER_MODE) begin
            mode_r <= power_mode_t'(hwdata[1:0]);
        end else begin
            unique case (mode_r)
                PM_IDLE_SUB, PM_SLEEP: begin
                    if (wake_armed && edge_seen_r) begin
                        mode_r <= PM_RUN;
                    end
                end
                PM_IDLE_FAST: begin
                    // an edge alone keeps the cpu halted
                    if (rx_done && wake_armed) begin
                        mode_r <= PM_RUN;
                    end
                end
                PM_RUN: ;
            endcase
        end
    end

    // start-up guard after a clock-restart wake
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            guard_r     <= 1'b0;
            guard_cnt_r <= '0;
            irq_hold_r  <= 1'b0;
        end else if (clk_off && wake_armed && edge_seen_r) begin
            guard_r     <= 1'b1;
            guard_cnt_r <= ($clog2(STARTUP_CYC+1))'(STARTUP_CYC);
            irq_hold_r  <= irq_ctrl_r[BIT_GLOBAL_IRQ] && irq_ctrl_r[BIT_SERIAL_IRQ];
        end else if (guard_r) begin
            if (guard_cnt_r == '0) begin
                guard_r    <= 1'b0;
                irq_hold_r <= 1'b0;
            end else begin
                guard_cnt_r <= guard_cnt_r - 1'b1;
            end
        end
    end

    // wake interrupt only after start-up, latched in its own EVT_WAKE event flag
    assign evt_set[EVT_WAKE]       = guard_r && guard_cnt_r == '0 && irq_hold_r;
    assign evt_set[EVT_RX_DONE]    = rx_done;
    assign evt_set[EVT_GUARD_DONE] = guard_r && guard_cnt_r == '0;
    assign serial_irq = evt_stat_r[EVT_WAKE] && irq_ctrl_r[BIT_GLOBAL_IRQ]
                     && irq_ctrl_r[BIT_SERIAL_IRQ];
    assign irq = |(evt_stat_r & evt_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= hsel && hready && htrans[1] && hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    // registers change only by writes, never by power mode
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            serial_control_one_r <= RST_CTRL;
            serial_control_two_r <= RST_CTRL;
            baud_divisor_reg_r   <= RST_BAUD;
            tx_data_r            <= RST_CTRL;
            irq_ctrl_r           <= 2'h0;
            evt_mask_r           <= '0;
        end else if (wr_pend_r) begin
            unique case (wr_addr_r)
                OFS_CTRL_ONE: serial_control_one_r <= hwdata[7:0];
                OFS_CTRL_TWO: serial_control_two_r <= hwdata[7:0];
                OFS_BAUD:     baud_divisor_reg_r   <= hwdata[7:0];
                OFS_TXDATA:   tx_data_r            <= hwdata[7:0];
                OFS_IRQ_CTRL: irq_ctrl_r           <= hwdata[1:0];
                OFS_EVT_MASK: evt_mask_r           <= hwdata[EVT_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky events, set wins over write-one-clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            evt_stat_r <= '0;
        end else begin
            if (wr_pend_r && wr_addr_r == OFS_EVT_STAT) begin
                evt_stat_r <= (evt_stat_r & ~hwdata[EVT_W-1:0]) | evt_set;
            end else begin
                evt_stat_r <= evt_stat_r | evt_set;
            end
        end
    end

    // read data registered in the address phase
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTRL_ONE:   hrdata <= {24'h0, serial_control_one_r};
                OFS_CTRL_TWO:   hrdata <= {24'h0, serial_control_two_r};
                OFS_STATUS:     hrdata <= {30'h0, rx_done, !rx_busy};
                OFS_BAUD:       hrdata <= {24'h0, baud_divisor_reg_r};
                OFS_TXDATA:     hrdata <= {24'h0, tx_data_r};
                OFS_RXDATA:     hrdata <= {24'h0, rx_data};
                OFS_IRQ_CTRL:   hrdata <= {30'h0, irq_ctrl_r};
                OFS_EVT_STAT:   hrdata <= {29'h0, evt_stat_r};
                OFS_EVT_MASK:   hrdata <= {29'h0, evt_mask_r};
                OFS_POWER_MODE: hrdata <= {30'h0, mode_r};
                default:        hrdata <= 32'h0;
            endcase
        end
    end
endmodule

// file: dv/rx_wakeup_ctrl_checker.sv
// port-level assertions for the receive-pin wake-up controller
module rx_wakeup_ctrl_checker
    import rxwake_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hsel,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rx_pin,
    input wire logic        sys_clk_run,
    input wire logic        cpu_wake,
    input wire logic        serial_irq,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic       tk;
    logic [9:0] since_r;
    ////////////////////////////////////////////////////////////////////////////
    // transfer taken this edge
    assign tk = hsel && hready && htrans[1];
    // cycles awake since the last wake; saturates so it never wraps
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) since_r <= 10'h3ff;
        else if (!cpu_wake) since_r <= 10'h0;
        else if (since_r != 10'h3ff) since_r <= since_r + 10'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus slave stalled or errored");
    property p_halt; !sys_clk_run |-> !cpu_wake; endproperty
    a_halt: assert property (p_halt) else $error("cpu awake without clock");
    property p_wake_clk; $rose(cpu_wake) |-> sys_clk_run; endproperty
    a_wake_clk: assert property (p_wake_clk) else $error("woke without clock");
    property p_fast_hold;
        sys_clk_run && !cpu_wake && $fell(rx_pin) && !tk && !$past(tk)
            |=> sys_clk_run && !cpu_wake;
    endproperty
    a_fast_hold: assert property (p_fast_hold) else $error("rx edge woke fast idle");
    property p_rd_hold; !$past(tk && !hwrite) |-> $stable(hrdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_irq_late; $rose(serial_irq) |-> since_r >= STARTUP_CYC - 1; endproperty
    a_irq_late: assert property (p_irq_late) else $error("wake irq before start-up");
    property p_irq_run; $rose(serial_irq) |-> cpu_wake && sys_clk_run; endproperty
    a_irq_run: assert property (p_irq_run) else $error("wake irq while halted");
    property p_sirq_fell; $fell(serial_irq) |-> $past(tk && hwrite, 2); endproperty
    a_sirq_fell: assert property (p_sirq_fell) else $error("serial irq dropped alone");
    property p_irq_fell; $fell(irq) |-> $past(tk && hwrite, 2); endproperty
    a_irq_fell: assert property (p_irq_fell) else $error("irq dropped without write");
    c_wake: cover property ($rose(cpu_wake) && !$past(sys_clk_run));
    c_sirq: cover property ($rose(serial_irq));
    c_irq:  cover property ($fell(irq));
endmodule
bind rx_wakeup_ctrl rx_wakeup_ctrl_checker u_rx_wakeup_ctrl_checker (
    .core_clk(core_clk), .resetn(resetn), .htrans(htrans), .hwrite(hwrite),
    .hsel(hsel), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_pin(rx_pin), .sys_clk_run(sys_clk_run),
    .cpu_wake(cpu_wake), .serial_irq(serial_irq), .irq(irq));

// file: dv/serial_tx_model.sv
// remote serial transmitter: one 8n1 frame, lsb first, per go pulse
module serial_tx_model (
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic [7:0] dat,
    input  wire logic [7:0] div,
    output logic            tx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] fr;
    // line idles high between frames; bit time is div+1 cycles
    initial tx_line = 1'b1;
    always @(posedge core_clk) begin
        if (go) begin
            fr = {1'b1, dat, 1'b0};
            for (int i = 0; i < 10; i++) begin
                tx_line <= fr[i];
                repeat (int'(div) + 1) @(posedge core_clk);
            end
        end
    end
endmodule

// file: dv/rx_wakeup_ctrl_bench.sv
// self-checking bench for the receive-pin wake-up controller
module rx_wakeup_ctrl_bench
    import rxwake_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, resetn = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [7:0]  dat = 8'h0, div = 8'h0;
    logic        hreadyout, hresp, rx_pin, sys_clk_run, cpu_wake, serial_irq, irq;
    int          miscompares = 0, check_count = 0, cyc = 0;
    rx_wakeup_ctrl u_rx_wakeup_ctrl (.core_clk(core_clk), .resetn(resetn), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_pin(rx_pin), .sys_clk_run(sys_clk_run), .cpu_wake(cpu_wake),
        .serial_irq(serial_irq), .irq(irq));
    serial_tx_model u_serial_tx_model (.core_clk(core_clk), .go(go), .dat(dat), .div(div),
        .tx_line(rx_pin));
    ////////////////////////////////////////////////////////////////////////////
    initial forever #20 core_clk = ~core_clk;
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard; the whole run needs well under 2000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected register at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected pin at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // single ahb-lite word transfer; waits on hready, never assumes a latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 50);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp_reg(q, e);
    endtask
    task automatic wait_wake(input int lim);
        int n = 0;
        while (cpu_wake !== 1'b1 && n++ < lim) @(posedge core_clk);
    endtask
    task automatic send(input logic [7:0] d, input logic [7:0] dv);
        dat <= d;
        div <= dv;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
    endtask
    // reset also clears the edge latch, which never clears by itself
    task automatic do_reset();
        resetn <= 1'b0;
        ticks(3);
        resetn <= 1'b1;
    endtask
    // reset is left to the caller, so irq control written before setup survives
    task automatic setup(input logic [31:0] c2, input logic [31:0] bd, input logic [31:0] pm);
        wr(OFS_CTRL_ONE, 32'h80);
        wr(OFS_CTRL_TWO, c2);
        wr(OFS_BAUD, bd);
        wr(OFS_POWER_MODE, pm);
    endtask
    // wake from sleep; mask polarity taken as one enables
    task automatic sleep_wake(input logic [31:0] ic, input logic [31:0] ev, input logic si);
        do_reset();
        wr(OFS_IRQ_CTRL, ic);
        setup(32'h4c, 32'h0, 32'h3);
        send(8'h5a, 8'h0);
        wait_wake(20);
        cmp_pin(cpu_wake, 1'b1);
        cmp_pin(sys_clk_run, 1'b1);
        cmp_pin(serial_irq, 1'b0);
        ticks(STARTUP_CYC - 5);
        cmp_pin(serial_irq, 1'b0);
        ticks(12);
        cmp_pin(serial_irq, si);
        rd_chk(OFS_EVT_STAT, ev);
        rd_chk(OFS_RXDATA, 32'h0);
        cmp_pin(irq, 1'b0);
        wr(OFS_EVT_MASK, 32'h7);
        ticks(1);
        cmp_pin(irq, 1'b1);
        wr(OFS_EVT_STAT, 32'h7);
        ticks(1);
        cmp_pin(irq, 1'b0);
        cmp_pin(serial_irq, 1'b0);
        $display("test sleep_wake done");
    endtask
    task automatic fast_idle(input logic [31:0] c2, input logic w);
        do_reset();
        setup(c2, 32'h3, 32'h2);
        send(8'ha5, 8'h3);
        ticks(5);
        cmp_pin(sys_clk_run, 1'b1);
        cmp_pin(cpu_wake, 1'b0);
        wait_wake(80);
        cmp_pin(cpu_wake, w);
        wr(OFS_POWER_MODE, 32'h0);
        rd_chk(OFS_RXDATA, 32'ha5);
        $display("test fast_idle done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        rd_chk(OFS_CTRL_TWO, {24'h0, RST_CTRL});
        rd_chk(OFS_STATUS, {24'h0, RST_STATUS});
        rd_chk(8'h40, 32'h0);
        // sub-clock idle with wake off: setup survives, no wake
        do_reset();
        setup(32'h40, 32'h27, 32'h1);
        ticks(1);
        cmp_pin(sys_clk_run, 1'b0);
        cmp_pin(cpu_wake, 1'b0);
        rd_chk(OFS_CTRL_ONE, 32'h80);
        rd_chk(OFS_CTRL_TWO, 32'h40);
        rd_chk(OFS_BAUD, 32'h27);
        rd_chk(OFS_STATUS, {24'h0, RST_STATUS});
        $display("test idle_keep done");
        sleep_wake(32'h3, 32'h5, 1'b1);
        sleep_wake(32'h1, 32'h4, 1'b0);
        fast_idle(32'h4c, 1'b1);
        fast_idle(32'h48, 1'b0);
        close_out();
    end
endmodule
